// ===== logic/torque_off_pkg.sv
// constants, offsets and modes of the torque disable trip and restart block
//
// Functional notes
// - safety input loss alone enters torque-off
// - torque-off raises fault, trips, coasts motor
// - prevention mode needs restored input plus reset
// - selector resets to 1; 3 means warning/auto
// - auto mode resumes once safety input restored, unless 72 latched
// - modes 1/3 thermistor trip gives latched 72
// - modes 4/5 external trip gives latched 72
// - modes 6 and 9 need reset to restart
// - modes 7 and 8 restart automatically
// - code 68 shown, alarm or warning class
// - brake engages on torque-off when configured
// - awaiting reset keeps coast and brake engaged
// - run commands ignored while torque-off active
// - configuration writes protected by password
package torque_off_pkg;

   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] MODE_OFS = 8'h04;
   localparam logic [7:0] STATUS_OFS = 8'h08;
   localparam logic [7:0] EVENT_OFS = 8'h0c;
   localparam logic [7:0] MASK_OFS = 8'h10;
   localparam logic [7:0] KEY_OFS = 8'h14;
   localparam logic [7:0] UNLOCK_OFS = 8'h18;

   // ------------------------------------------------------------
   // control bits and event bits
   // ------------------------------------------------------------
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_RESET_BIT = 1;
   localparam int CTRL_BRAKE_BIT = 2;
   localparam int EV_TRIP_BIT = 0;
   localparam int EV_DANGER_BIT = 1;
   localparam int EV_RESTART_BIT = 2;
   localparam int EV_REFUSED_BIT = 3;
   localparam int EV_WIDTH = 4;

   // ------------------------------------------------------------
   // selector values and reset values
   // ------------------------------------------------------------
   localparam logic [3:0] MODE_ALARM = 4'h1;
   localparam logic [3:0] MODE_WARNING = 4'h3;
   localparam logic [3:0] thermistor_only_alarm_mode = 4'h4;
   localparam logic [3:0] thermistor_only_warning_mode = 4'h5;
   localparam logic [3:0] combined_alarm_mode = 4'h6;
   localparam logic [3:0] combined_warning_mode = 4'h7;
   localparam logic [3:0] combined_alarm_warning_mode = 4'h8;
   localparam logic [3:0] combined_warning_alarm_mode = 4'h9;
   localparam logic [3:0] MODE_RESET = MODE_ALARM;
   localparam logic [2:0] CTRL_RESET = 3'h0;
   localparam logic [EV_WIDTH-1:0] MASK_RESET = 4'h0;

   // ------------------------------------------------------------
   // displayed codes and synchroniser depth
   // ------------------------------------------------------------
   localparam logic [7:0] CODE_NONE = 8'h00;
   localparam logic [7:0] CODE_SAFE_STOP = 8'h44;   // 68
   localparam logic [7:0] CODE_DANGER = 8'h48;      // 72
   localparam int SYNC_STAGES = 2;

   typedef enum logic [1:0] {ST_RUN, ST_OFF, ST_WAIT} trip_state_e;

   // restart-prevention modes need a reset after the input returns
   function automatic logic needs_reset(input logic [3:0] m);
      needs_reset = (m == MODE_ALARM) || (m == thermistor_only_alarm_mode) ||
                    (m == combined_alarm_mode) ||
                    (m == combined_warning_alarm_mode);
   endfunction

   // selector values legal for the fitted hardware
   function automatic logic mode_legal(input logic [3:0] m,
                                       input logic card);
      mode_legal = (m == MODE_ALARM) || (m == MODE_WARNING) ||
                   (card && m >= thermistor_only_alarm_mode &&
                    m <= combined_warning_alarm_mode);
   endfunction

endpackage

// ===== logic/level_sync.sv
// two flip-flop level synchroniser for asynchronous inputs
`timescale 1ns/1ps
module level_sync
#(
   parameter int WIDTH = 2
)
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // levels
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   // --------------------------------------------------------------
   // first stage feeds only the second; resets to the safe low level
   // --------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         meta_reg <= '0;
         sync_reg <= '0;
      end
      else
      begin
         meta_reg <= asyncIn;
         sync_reg <= meta_reg;
      end
   end

   assign syncOut = sync_reg;

endmodule // level_sync

// ===== logic/config_lock.sv
// password lock that guards the configuration writes
`timescale 1ns/1ps
module config_lock
#(
   parameter int KEY_WIDTH = 16
)
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // key writes
   input wire logic keyWr,
   input wire logic unlockWr,
   input wire logic [KEY_WIDTH-1:0] keyData,
   // state
   output logic locked
);

   logic [KEY_WIDTH-1:0] key_reg;
   logic [KEY_WIDTH-1:0] key_next;
   logic locked_reg;
   logic locked_next;

   // --------------------------------------------------------------
   // a nonzero key locks; only the same key unlocks again
   // --------------------------------------------------------------
   always_comb
   begin
      key_next = key_reg;
      locked_next = locked_reg;
      if (!locked_reg && keyWr && keyData != '0)
      begin
         key_next = keyData;
         locked_next = 1'b1;
      end
      else if (locked_reg && unlockWr && keyData == key_reg)
      begin
         locked_next = 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         key_reg <= '0;
         locked_reg <= 1'b0;
      end
      else
      begin
         key_reg <= key_next;
         locked_reg <= locked_next;
      end
   end

   assign locked = locked_reg;

endmodule // config_lock

// ===== logic/torque_off_trip.sv
// trip and restart logic of the torque disable function
`timescale 1ns/1ps
module torque_off_trip
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // safety inputs, asynchronous
   input wire logic safetyIn,
   input wire logic thermistorTripOutput,
   input wire logic thermCardFitted,
   // reset sources other than the bus, one-cycle pulses
   input wire logic digitalReset,
   input wire logic panelResetKey,
   // drive outputs
   output logic motorEnable,
   output logic brakeEngage,
   output logic [7:0] faultCode,
   output logic faultAlarm,
   output logic faultWarning,
   output logic irq
);

   // --------------------------------------------------------------
   // synchronised inputs
   // --------------------------------------------------------------
   logic [1:0] syncLevels;
   logic safeOk;
   logic thermOk;

   // safety input and thermistor trip cross into clk first
   level_sync #(.WIDTH(2)) level_sync_i
   (
      .clk(clk),
      .srst(srst),
      .asyncIn({thermistorTripOutput, safetyIn}),
      .syncOut(syncLevels)
   );
   assign safeOk = syncLevels[0];
   assign thermOk = syncLevels[1];

   // --------------------------------------------------------------
   // bus decode
   // --------------------------------------------------------------
   logic ack_reg;
   logic busWr;
   logic busRd;
   logic wrLow;
   logic locked;

   // ack one cycle after the strobe; writes land on the ack edge
   assign busWr = cyc_i && stb_i && ack_reg && we_i;
   assign busRd = cyc_i && stb_i && ack_reg && !we_i;
   assign wrLow = busWr && sel_i[0];
   assign ack_o = ack_reg;

   config_lock #(.KEY_WIDTH(16)) config_lock_i
   (
      .clk(clk),
      .srst(srst),
      .keyWr(busWr && sel_i[1:0] == 2'b11 &&
             adr_i == torque_off_pkg::KEY_OFS),
      .unlockWr(busWr && sel_i[1:0] == 2'b11 &&
                adr_i == torque_off_pkg::UNLOCK_OFS),
      .keyData(dat_i[15:0]),
      .locked(locked)
   );

   // --------------------------------------------------------------
   // configuration and control registers
   // --------------------------------------------------------------
   logic [3:0] mode_reg;
   logic [3:0] mode_next;
   logic run_reg;
   logic run_next;
   logic brakeCfg_reg;
   logic brakeCfg_next;
   logic [torque_off_pkg::EV_WIDTH-1:0] mask_reg;
   logic [torque_off_pkg::EV_WIDTH-1:0] mask_next;
   logic modeWr;
   logic modeRefused;
   logic resetReq;
   torque_off_pkg::trip_state_e state_reg;
   torque_off_pkg::trip_state_e state_next;

   assign modeWr = wrLow && adr_i == torque_off_pkg::MODE_OFS;
   // locked or illegal selector writes are dropped and flagged
   assign modeRefused = modeWr && (locked ||
      !torque_off_pkg::mode_legal(dat_i[3:0], thermCardFitted));
   // any of the three reset sources
   assign resetReq = digitalReset || panelResetKey ||
      (wrLow && adr_i == torque_off_pkg::CTRL_OFS &&
       dat_i[torque_off_pkg::CTRL_RESET_BIT]);

   always_comb
   begin
      mode_next = mode_reg;
      run_next = run_reg;
      brakeCfg_next = brakeCfg_reg;
      mask_next = mask_reg;
      if (modeWr && !modeRefused)
      begin
         mode_next = dat_i[3:0];
      end
      if (wrLow && adr_i == torque_off_pkg::CTRL_OFS)
      begin
         // a start while tripped is ignored; stop is always taken
         if (state_reg == torque_off_pkg::ST_RUN ||
             !dat_i[torque_off_pkg::CTRL_RUN_BIT])
         begin
            run_next = dat_i[torque_off_pkg::CTRL_RUN_BIT];
         end
         if (!locked)
         begin
            brakeCfg_next = dat_i[torque_off_pkg::CTRL_BRAKE_BIT];
         end
      end
      if (wrLow && adr_i == torque_off_pkg::MASK_OFS)
      begin
         mask_next = dat_i[torque_off_pkg::EV_WIDTH-1:0];
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         mode_reg <= torque_off_pkg::MODE_RESET;
         run_reg <= torque_off_pkg::CTRL_RESET[0];
         brakeCfg_reg <= torque_off_pkg::CTRL_RESET[2];
         mask_reg <= torque_off_pkg::MASK_RESET;
      end
      else
      begin
         mode_reg <= mode_next;
         run_reg <= run_next;
         brakeCfg_reg <= brakeCfg_next;
         mask_reg <= mask_next;
      end
   end

   // --------------------------------------------------------------
   // trip state machine
   // --------------------------------------------------------------
   logic danger_reg;
   logic danger_next;
   logic dangerHit;
   logic thermOnlyMode;
   logic prevent;

   assign thermOnlyMode = mode_reg == torque_off_pkg::thermistor_only_alarm_mode
      || mode_reg == torque_off_pkg::thermistor_only_warning_mode;
   // the wrong source for the selected mode is a dangerous failure
   assign dangerHit = !safeOk && (
      (!thermOk && (mode_reg == torque_off_pkg::MODE_ALARM ||
                    mode_reg == torque_off_pkg::MODE_WARNING)) ||
      (thermOk && thermOnlyMode));
   assign prevent = torque_off_pkg::needs_reset(mode_reg);

   always_comb
   begin
      state_next = state_reg;
      danger_next = danger_reg || dangerHit;   // latched until restart
      unique case (state_reg)
         torque_off_pkg::ST_RUN:
         begin
            if (!safeOk)
            begin
               state_next = torque_off_pkg::ST_OFF;
            end
         end
         torque_off_pkg::ST_OFF:
         begin
            if (safeOk)
            begin
               // danger blocks the automatic path
               if (prevent || danger_reg)
               begin
                  state_next = torque_off_pkg::ST_WAIT;
               end
               else
               begin
                  state_next = torque_off_pkg::ST_RUN;
                  danger_next = 1'b0;
               end
            end
         end
         torque_off_pkg::ST_WAIT:
         begin
            if (!safeOk)
            begin
               state_next = torque_off_pkg::ST_OFF;
            end
            else if (resetReq)
            begin
               state_next = torque_off_pkg::ST_RUN;
               danger_next = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state_reg <= torque_off_pkg::ST_RUN;
         danger_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         danger_reg <= danger_next;
      end
   end

   // --------------------------------------------------------------
   // drive outputs, all from flip-flops
   // --------------------------------------------------------------
   logic motor_reg;
   logic brake_reg;
   logic [7:0] code_reg;
   logic alarm_reg;
   logic warn_reg;
   logic tripped;

   assign tripped = state_next != torque_off_pkg::ST_RUN;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         motor_reg <= 1'b0;
         brake_reg <= 1'b0;
         code_reg <= torque_off_pkg::CODE_NONE;
         alarm_reg <= 1'b0;
         warn_reg <= 1'b0;
      end
      else
      begin
         motor_reg <= !tripped && run_next;
         brake_reg <= tripped && brakeCfg_next;
         code_reg <= !tripped ? torque_off_pkg::CODE_NONE :
            danger_next ? torque_off_pkg::CODE_DANGER :
            torque_off_pkg::CODE_SAFE_STOP;
         alarm_reg <= tripped && (prevent || danger_next);
         warn_reg <= tripped && !(prevent || danger_next);
      end
   end

   assign motorEnable = motor_reg;
   assign brakeEngage = brake_reg;
   assign faultCode = code_reg;
   assign faultAlarm = alarm_reg;
   assign faultWarning = warn_reg;

   // --------------------------------------------------------------
   // sticky events, read clears, set wins over the clear
   // --------------------------------------------------------------
   logic [torque_off_pkg::EV_WIDTH-1:0] ev_reg;
   logic [torque_off_pkg::EV_WIDTH-1:0] ev_next;
   logic [torque_off_pkg::EV_WIDTH-1:0] evSet;
   logic evClr;

   assign evSet = {modeRefused,
      state_reg != torque_off_pkg::ST_RUN && !tripped,
      dangerHit && !danger_reg,
      state_reg == torque_off_pkg::ST_RUN && tripped};
   assign evClr = busRd && adr_i == torque_off_pkg::EVENT_OFS;

   always_comb
   begin
      ev_next = (evClr ? '0 : ev_reg) | evSet;
   end

   // --------------------------------------------------------------
   // bus answer: ack and read data registered together
   // --------------------------------------------------------------
   logic [31:0] rd_reg;
   logic [31:0] rd_next;
   logic irq_reg;

   always_comb
   begin
      rd_next = 32'h0000_0000;   // unmapped reads answer zero
      unique case (adr_i)
         torque_off_pkg::CTRL_OFS:
            rd_next = {29'h0, brakeCfg_reg, 1'b0, run_reg};
         torque_off_pkg::MODE_OFS: rd_next = {28'h0, mode_reg};
         torque_off_pkg::STATUS_OFS:
            rd_next = {14'h0, warn_reg, alarm_reg, code_reg,
                       1'b0, thermCardFitted, thermOk, safeOk,
                       locked, danger_reg, state_reg};
         torque_off_pkg::EVENT_OFS: rd_next = {28'h0, ev_reg};
         torque_off_pkg::MASK_OFS: rd_next = {28'h0, mask_reg};
         default: rd_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         ack_reg <= 1'b0;
         rd_reg <= 32'h0000_0000;
         ev_reg <= '0;
         irq_reg <= 1'b0;
      end
      else
      begin
         ack_reg <= cyc_i && stb_i && !ack_reg;
         rd_reg <= rd_next;
         ev_reg <= ev_next;
         irq_reg <= |(ev_next & mask_reg);
      end
   end

   assign dat_o = rd_reg;
   assign irq = irq_reg;

   // --------------------------------------------------------------
   // assertions
   // --------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence s_lost;
      state_reg == torque_off_pkg::ST_RUN && !safeOk;
   endsequence

   // a clean stop with a steady selector: class follows the mode alone
   sequence s_plain_off;
      state_reg != torque_off_pkg::ST_RUN && !danger_reg && !dangerHit ##1
      state_reg != torque_off_pkg::ST_RUN && $stable(mode_reg);
   endsequence

   // outputs are registered from state_next, so they match state_reg
   a_loss_trips: assert property (s_lost |=>
      state_reg == torque_off_pkg::ST_OFF && !motorEnable)
      else $error("safety loss did not trip");
   a_trip_coasts: assert property (
      state_reg != torque_off_pkg::ST_RUN |->
      !motorEnable && faultCode != torque_off_pkg::CODE_NONE)
      else $error("motor driven while tripped");
   a_wait_reset: assert property (
      state_reg == torque_off_pkg::ST_WAIT && safeOk && !resetReq
      |=> state_reg == torque_off_pkg::ST_WAIT)
      else $error("left wait without reset");
   a_auto_restart: assert property (
      state_reg == torque_off_pkg::ST_OFF && safeOk && !prevent &&
      !danger_reg |=> state_reg == torque_off_pkg::ST_RUN)
      else $error("auto restart missing");
   a_mode_legal: assert property (
      torque_off_pkg::mode_legal(mode_reg, 1'b1))
      else $error("illegal selector value held");
   a_danger_code: assert property (dangerHit |=>
      faultCode == torque_off_pkg::CODE_DANGER && faultAlarm)
      else $error("dangerous failure not shown");
   a_wait_brake: assert property (
      state_reg == torque_off_pkg::ST_WAIT && brakeCfg_reg
      |-> brakeEngage && !motorEnable)
      else $error("brake released before reset");
   a_class_68: assert property (s_plain_off |->
      faultAlarm == prevent && faultWarning == !prevent)
      else $error("code 68 class wrong");
   a_run_ignored: assert property (
      state_reg != torque_off_pkg::ST_RUN && !run_reg |=> !run_reg)
      else $error("start taken while tripped");
   a_lock_mode: assert property (
      locked && modeWr |=> $stable(mode_reg))
      else $error("locked selector changed");

endmodule // torque_off_trip

// ===== tb/safety_source_model.sv
// behavioural safety relay that ands the sensor with the thermistor card
`timescale 1ns/1ps
module safety_source_model
(
   // healthy levels set by the bench
   input wire logic sensorOk,
   input wire logic cardOk,
   // levels seen by the drive
   output logic safetyIn,
   output logic thermistorTripOutput
);
   // ------------------------------------------------------------
   // and-combination of both safety channels
   // ------------------------------------------------------------
   // one low channel is enough to remove the enable supply
   assign safetyIn = sensorOk & cardOk;
   assign thermistorTripOutput = cardOk;
endmodule // safety_source_model

// ===== tb/safe_torque_off_trip_restart_tb_top.sv
// self-checking bench of the torque disable trip and restart block
`timescale 1ns/1ps
module safe_torque_off_trip_restart_tb_top;
   // ------------------------------------------------------------
   // stimulus and observed signals
   // ------------------------------------------------------------
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdo;
   logic [31:0] rdData;
   logic ack;
   logic sensorOk = 1'b1;
   logic cardOk = 1'b1;
   logic fitted = 1'b0;
   logic digitalReset = 1'b0;
   logic panelResetKey = 1'b0;
   logic safetyIn;
   logic thermTrip;
   logic motorEnable;
   logic brakeEngage;
   logic [7:0] faultCode;
   logic faultAlarm;
   logic faultWarning;
   logic irq;
   int badCount = 0;
   int checksDone = 0;

   // 100 MHz clock
   always #5 clk = ~clk;

   safety_source_model safety_source_model_i (.sensorOk(sensorOk),
      .cardOk(cardOk), .safetyIn(safetyIn), .thermistorTripOutput(thermTrip));

   torque_off_trip torque_off_trip_i (.clk(clk), .srst(srst), .cyc_i(cyc),
      .stb_i(cyc), .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wdat),
      .dat_o(rdo), .ack_o(ack), .safetyIn(safetyIn),
      .thermistorTripOutput(thermTrip), .thermCardFitted(fitted),
      .digitalReset(digitalReset), .panelResetKey(panelResetKey),
      .motorEnable(motorEnable), .brakeEngage(brakeEngage),
      .faultCode(faultCode), .faultAlarm(faultAlarm),
      .faultWarning(faultWarning), .irq(irq));

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task check(input string nm, input logic [31:0] e, input logic [31:0] g);
      checksDone++;
      if (g !== e)
      begin
         badCount++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task end_of_test;
      if (badCount == 0 && checksDone > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // one classic cycle; the slave decides when it answers
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      rdData = rdo;
      cyc <= 1'b0;
      if (ack !== 1'b1)
         check("ack", 32'h1, 32'h0);
   endtask

   // bounded wait on the drive enable, then compare
   task wait_motor(input logic e);
      int n;
      n = 0;
      while (motorEnable !== e && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      check("motorEnable", e, motorEnable);
   endtask

   // reset request from input pin, panel key or the bus
   task reset_by(input int src);
      if (src == 2)
         bus(1'b1, torque_off_pkg::CTRL_OFS, 32'h7);
      else
      begin
         @(posedge clk);
         digitalReset <= (src == 0);
         panelResetKey <= (src == 1);
         @(posedge clk);
         digitalReset <= 1'b0;
         panelResetKey <= 1'b0;
      end
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   // trip in mode m by sensor or card, restore, restart as mode demands
   task mode_cycle(input logic [3:0] m, input logic autoOn,
                   input logic byCard, input int src);
      logic danger;
      logic autoGo;
      danger = byCard ? (m == 4'h1 || m == 4'h3) : (m == 4'h4 || m == 4'h5);
      autoGo = autoOn && !danger;
      bus(1'b1, torque_off_pkg::MODE_OFS, {28'h0, m});
      bus(1'b0, torque_off_pkg::MODE_OFS, 32'h0);
      check("mode", m, rdData[3:0]);
      @(posedge clk);
      sensorOk <= byCard;
      cardOk <= !byCard;
      wait_motor(1'b0);
      check("brake", 1, brakeEngage);
      check("code", danger ? 8'h48 : 8'h44, faultCode);
      check("alarm", !autoGo, faultAlarm);
      check("warning", autoGo, faultWarning);
      // stop is taken while tripped, a fresh start is not
      bus(1'b1, torque_off_pkg::CTRL_OFS, 32'h4);
      bus(1'b1, torque_off_pkg::CTRL_OFS, 32'h5);
      bus(1'b0, torque_off_pkg::CTRL_OFS, 32'h0);
      check("run ignored", 32'h4, rdData);
      check("coasting", 0, motorEnable);
      sensorOk <= 1'b1;
      cardOk <= 1'b1;
      repeat (10) @(posedge clk);
      if (!autoGo)
      begin
         check("held coast", 0, motorEnable);
         check("held brake", 1, brakeEngage);
         reset_by(src);
         repeat (4) @(posedge clk);
      end
      bus(1'b0, torque_off_pkg::STATUS_OFS, 32'h0);
      check("state run", 2'h0, rdData[1:0]);
      check("code clear", 8'h00, faultCode);
      check("brake off", 0, brakeEngage);
      bus(1'b1, torque_off_pkg::CTRL_OFS, 32'h5);
      wait_motor(1'b1);
   endtask

   // masked and unmasked trip event on the level interrupt
   task irq_test;
      check("irq masked", 0, irq);
      bus(1'b1, torque_off_pkg::MASK_OFS, 32'h1);
      bus(1'b0, torque_off_pkg::EVENT_OFS, 32'h0);
      repeat (2) @(posedge clk);
      check("irq cleared", 0, irq);
      sensorOk <= 1'b0;
      wait_motor(1'b0);
      repeat (2) @(posedge clk);
      check("irq raised", 1, irq);
      bus(1'b0, torque_off_pkg::EVENT_OFS, 32'h0);
      check("trip event", 1, rdData[0]);
      sensorOk <= 1'b1;
      wait_motor(1'b1);
      repeat (2) @(posedge clk);
      check("irq after read", 0, irq);
      bus(1'b1, torque_off_pkg::MASK_OFS, 32'h0);
   endtask

   // card-only selector values, password lock and an unmapped place
   task config_test;
      bus(1'b1, torque_off_pkg::MODE_OFS, 32'h4);
      bus(1'b0, torque_off_pkg::MODE_OFS, 32'h0);
      check("mode no card", 4'h3, rdData[3:0]);
      bus(1'b0, torque_off_pkg::EVENT_OFS, 32'h0);
      check("refused event", 1, rdData[3]);
      fitted <= 1'b1;
      bus(1'b1, torque_off_pkg::KEY_OFS, 32'h1234);
      bus(1'b1, torque_off_pkg::MODE_OFS, 32'h6);
      bus(1'b0, torque_off_pkg::MODE_OFS, 32'h0);
      check("mode locked", 4'h3, rdData[3:0]);
      bus(1'b0, torque_off_pkg::STATUS_OFS, 32'h0);
      check("locked", 1, rdData[3]);
      bus(1'b1, torque_off_pkg::UNLOCK_OFS, 32'h1234);
      bus(1'b0, torque_off_pkg::STATUS_OFS, 32'h0);
      check("unlocked", 0, rdData[3]);
      bus(1'b0, 8'h1c, 32'h0);
      check("unmapped", 32'h0, rdData);
   endtask

   // ------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------
   initial
   begin
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      repeat (4) @(posedge clk);
      reset_by(0);
      bus(1'b0, torque_off_pkg::MODE_OFS, 32'h0);
      check("mode reset", 4'h1, rdData[3:0]);
      bus(1'b1, torque_off_pkg::CTRL_OFS, 32'h5);
      wait_motor(1'b1);
      mode_cycle(4'h1, 1'b0, 1'b0, 0);
      mode_cycle(4'h3, 1'b1, 1'b0, 0);
      irq_test();
      config_test();
      mode_cycle(4'h3, 1'b1, 1'b1, 1);
      mode_cycle(4'h4, 1'b0, 1'b0, 2);
      mode_cycle(4'h6, 1'b0, 1'b0, 0);
      mode_cycle(4'h7, 1'b1, 1'b0, 0);
      mode_cycle(4'h8, 1'b1, 1'b0, 0);
      mode_cycle(4'h9, 1'b0, 1'b0, 1);
      end_of_test();
   end

   // whole run needs under a thousand cycles; this is twenty times that
   initial
   begin
      #200000;
      badCount++;
      end_of_test();
   end
endmodule // safe_torque_off_trip_restart_tb_top
